// File: include/ench_pkg.sv
package ench_pkg;
    // command bytes
    localparam logic [7:0] CMD_RD_POS = 8'h42;
    localparam logic [7:0] CMD_SET_POS = 8'h43;
    localparam logic [7:0] CMD_RD_ANA = 8'h44;
    localparam logic [7:0] CMD_RD_CNT = 8'h46;
    localparam logic [7:0] CMD_INC_CNT = 8'h47;
    localparam logic [7:0] CMD_CLR_CNT = 8'h49;
    localparam logic [7:0] CMD_RD_DATA = 8'h4A;
    localparam logic [7:0] CMD_ST_DATA = 8'h4B;
    localparam logic [7:0] CMD_FLD_STAT = 8'h4C;
    localparam logic [7:0] CMD_MK_FLD = 8'h4D;
    localparam logic [7:0] CMD_MEM_FREE = 8'h4E;
    localparam logic [7:0] CMD_CHG_CODE = 8'h4F;
    localparam logic [7:0] CMD_RD_STAT = 8'h50;
    localparam logic [7:0] CMD_RD_TYPE = 8'h52;
    localparam logic [7:0] CMD_RESET = 8'h53;
    localparam logic [7:0] CMD_SET_ADDR = 8'h55;
    localparam logic [7:0] CMD_SERNUM = 8'h56;
    localparam logic [7:0] CMD_CFG_LINK = 8'h57;
    // status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_OFFSET = 8'h02;
    localparam logic [7:0] ST_PART_TBL = 8'h03;
    localparam logic [7:0] ST_NVM_BUS = 8'h05;
    localparam logic [7:0] ST_WDOG = 8'h07;
    localparam logic [7:0] ST_CHKSUM = 8'h0A;
    localparam logic [7:0] ST_UNK_CMD = 8'h0B;
    localparam logic [7:0] ST_LEN = 8'h0C;
    localparam logic [7:0] ST_ARG = 8'h0D;
    localparam logic [7:0] ST_WPROT = 8'h0E;
    localparam logic [7:0] ST_CODE = 8'h0F;
    localparam logic [7:0] ST_FIXSIZE = 8'h10;
    localparam logic [7:0] ST_WADDR = 8'h11;
    localparam logic [7:0] ST_NOFLD = 8'h12;
    localparam logic [7:0] ST_ANA_MON = 8'h1C;
    localparam logic [7:0] ST_SPEED = 8'h1F;
    // reset values and sizes
    localparam logic [7:0] PROT_RST = 8'h55;
    localparam logic [7:0] ADDR_RST = 8'h40;
    localparam logic [7:0] MODE_RST = 8'hE4;
    localparam logic [7:0] MEM_TOTAL = 8'h80;
    localparam int NFLD = 4;
    localparam int NFLD_W = 2;
    // arbitrary identity values
    localparam logic [7:0] TYPE_ID = 8'hA5;
    localparam logic [31:0] SER_NUM = 32'h0000_1234;
    localparam logic [7:0] FW_VER = 8'h01;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] prot;
        logic [7:0] arg0;
        logic [7:0] arg1;
        logic [7:0] arg2;
        logic [2:0] nbytes;
        logic chk_ok;
    } ench_req_s;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        logic [7:0] d4;
    } ench_rsp_s;

    typedef struct packed {
        logic offset_bad;
        logic part_tbl_bad;
        logic nvm_bus_bad;
        logic wdog_rst;
        logic speed_high;
        logic ana_mon;
    } ench_flt_s;

    typedef struct packed {
        logic exists;
        logic wprot;
        logic fixsize;
        logic [7:0] size;
    } ench_fld_s;
endpackage : ench_pkg

// File: rtl/ench_flt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ench_flt_sync
    import ench_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire ench_flt_s flt_in,
    output logic [7:0] code_out
);
    ench_flt_s meta_ff;
    ench_flt_s sync_ff;

    // fault pins are asynchronous; only the second stage is decoded
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= flt_in;
            sync_ff <= meta_ff;
        end
    end

    // priority: init faults first, then watchdog, position, others
    always_comb begin
        code_out = ST_OK;
        if (sync_ff.offset_bad) begin
            code_out = ST_OFFSET;
        end else if (sync_ff.part_tbl_bad) begin
            code_out = ST_PART_TBL;
        end else if (sync_ff.nvm_bus_bad) begin
            code_out = ST_NVM_BUS;
        end else if (sync_ff.wdog_rst) begin
            code_out = ST_WDOG;
        end else if (sync_ff.speed_high) begin
            code_out = ST_SPEED;
        end else if (sync_ff.ana_mon) begin
            code_out = ST_ANA_MON;
        end
    end
endmodule : ench_flt_sync
`default_nettype wire

// File: rtl/ench_top.sv
// Function
// - set position, set address, configure link need matching protection byte
// - protection value is 55h after reset
// - status 00h when no fault detected
// - status 02h on invalid angular offset
// - status 03h on corrupted field partition table
// - status 05h on failed memory bus
// - status 07h after watchdog reset
// - bad checksum frame is rejected with status 0Ah
// - wrong data byte count gives status 0Ch
// - disallowed argument gives status 0Dh
// - store into write protected field refused with 0Eh
// - resizing fixed size field gives status 10h
// - word address beyond field end gives status 11h
// - access to absent field gives status 12h
// - status 1Fh when speed too high for position
// - status 1Ch on analog value monitoring violation
// - command 56h returns serial number and firmware version
// - command 4Ch returns status of named field
// - command 4Eh returns free memory
`timescale 1ns/1ps
`default_nettype none
module ench_top
    import ench_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic REQ_VALID_IN,
    input wire ench_req_s REQ_IN,
    input wire logic [14:0] POS_IN,
    input wire ench_flt_s FLT_IN,
    output logic RSP_VALID_OUT,
    output ench_rsp_s RSP_OUT,
    output logic [14:0] POS_OFS_OUT,
    output logic [7:0] LINK_ADDR_OUT,
    output logic [7:0] LINK_MODE_OUT,
    output logic RESET_REQ_OUT
);
    logic [7:0] flt_code;
    logic [7:0] prot_ff;
    logic [7:0] addr_ff;
    logic [7:0] mode_ff;
    logic [14:0] ofs_ff;
    logic [15:0] cnt_ff;
    logic [7:0] last_err_ff;
    ench_fld_s fld_ff [NFLD];
    logic [7:0] mem [NFLD][16];
    logic rsp_valid_ff;
    ench_rsp_s rsp_ff;
    logic rst_req_ff;
    logic [7:0] used;
    logic [7:0] free_mem;
    ench_rsp_s nxt_rsp;
    logic [NFLD_W-1:0] fi;
    logic [3:0] wi;
    logic do_exec;

    ench_flt_sync u_flt (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .flt_in(FLT_IN),
        .code_out(flt_code)
    );

    function automatic logic [2:0] exp_len(input logic [7:0] c);
        unique case (c)
            CMD_SET_POS, CMD_SET_ADDR, CMD_CFG_LINK: exp_len = 3'h3;
            CMD_RD_DATA, CMD_MK_FLD: exp_len = 3'h2;
            CMD_ST_DATA: exp_len = 3'h3;
            CMD_FLD_STAT, CMD_CHG_CODE, CMD_RD_ANA: exp_len = 3'h1;
            default: exp_len = 3'h0;
        endcase
    endfunction : exp_len

    function automatic logic known_cmd(input logic [7:0] c);
        unique case (c)
            CMD_RD_POS, CMD_SET_POS, CMD_RD_ANA, CMD_RD_CNT, CMD_INC_CNT,
            CMD_CLR_CNT, CMD_RD_DATA, CMD_ST_DATA, CMD_FLD_STAT, CMD_MK_FLD,
            CMD_MEM_FREE, CMD_CHG_CODE, CMD_RD_STAT, CMD_RD_TYPE, CMD_RESET,
            CMD_SET_ADDR, CMD_SERNUM, CMD_CFG_LINK: known_cmd = 1'b1;
            default: known_cmd = 1'b0;
        endcase
    endfunction : known_cmd

    function automatic logic needs_prot(input logic [7:0] c);
        needs_prot = (c == CMD_SET_POS) || (c == CMD_SET_ADDR) || (c == CMD_CFG_LINK);
    endfunction : needs_prot

    assign fi = REQ_IN.arg0[NFLD_W-1:0];
    assign wi = REQ_IN.arg1[3:0];

    always_comb begin
        used = 8'h00;
        for (int i = 0; i < NFLD; i++) begin
            if (fld_ff[i].exists) begin
                used = used + fld_ff[i].size;
            end
        end
        free_mem = MEM_TOTAL - used;
    end

    // validation order: checksum, command, length, protection, then field checks
    always_comb begin
        nxt_rsp = '0;
        do_exec = 1'b0;
        nxt_rsp.status = ST_OK;
        if (!REQ_IN.chk_ok) begin
            nxt_rsp.status = ST_CHKSUM;
        end else if (!known_cmd(REQ_IN.cmd)) begin
            nxt_rsp.status = ST_UNK_CMD;
        end else if (REQ_IN.nbytes != exp_len(REQ_IN.cmd)) begin
            nxt_rsp.status = ST_LEN;
        end else if (needs_prot(REQ_IN.cmd) && REQ_IN.prot != prot_ff) begin
            nxt_rsp.status = ST_CODE;
        end else begin
            do_exec = 1'b1;
            unique case (REQ_IN.cmd)
                CMD_RD_POS: begin
                    nxt_rsp.status = flt_code;
                    if (flt_code != ST_SPEED) begin
                        {nxt_rsp.d0, nxt_rsp.d1} = {1'b0, POS_IN - ofs_ff};
                    end
                end
                CMD_RD_CNT: {nxt_rsp.d0, nxt_rsp.d1} = cnt_ff;
                CMD_RD_STAT: nxt_rsp.d0 = (flt_code != ST_OK) ? flt_code : last_err_ff;
                CMD_RD_TYPE: nxt_rsp.d0 = TYPE_ID;
                CMD_SERNUM: begin
                    {nxt_rsp.d0, nxt_rsp.d1, nxt_rsp.d2, nxt_rsp.d3} = SER_NUM;
                    nxt_rsp.d4 = FW_VER;
                end
                CMD_MEM_FREE: nxt_rsp.d0 = free_mem;
                CMD_FLD_STAT: begin
                    if (REQ_IN.arg0 >= 8'(NFLD) || !fld_ff[fi].exists) begin
                        nxt_rsp.status = ST_NOFLD;
                    end else begin
                        nxt_rsp.d0 = fld_ff[fi].size;
                        nxt_rsp.d1 = {6'h00, fld_ff[fi].fixsize, fld_ff[fi].wprot};
                    end
                end
                CMD_RD_DATA, CMD_ST_DATA: begin
                    if (REQ_IN.arg0 >= 8'(NFLD) || !fld_ff[fi].exists) begin
                        nxt_rsp.status = ST_NOFLD;
                    end else if (REQ_IN.arg1 >= fld_ff[fi].size) begin
                        nxt_rsp.status = ST_WADDR;
                    end else if (REQ_IN.cmd == CMD_ST_DATA && fld_ff[fi].wprot) begin
                        nxt_rsp.status = ST_WPROT;
                    end else begin
                        nxt_rsp.d0 = mem[fi][wi];
                    end
                end
                CMD_MK_FLD: begin
                    if (REQ_IN.arg0 >= 8'(NFLD)) begin
                        nxt_rsp.status = ST_ARG;
                    end else if (fld_ff[fi].exists && fld_ff[fi].fixsize) begin
                        nxt_rsp.status = ST_FIXSIZE;
                    end else if (REQ_IN.arg1 == 8'h00 || REQ_IN.arg1 > 8'h10) begin
                        nxt_rsp.status = ST_ARG;
                    end
                end
                CMD_RD_ANA: begin
                    if (REQ_IN.arg0 != 8'h48) begin
                        nxt_rsp.status = ST_ARG;
                    end
                end
                default: nxt_rsp.status = ST_OK;
            endcase
        end
    end

    // protection byte, link settings and position offset
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            prot_ff <= PROT_RST;
            addr_ff <= ADDR_RST;
            mode_ff <= MODE_RST;
            ofs_ff <= '0;
        end else if (REQ_VALID_IN && do_exec && nxt_rsp.status == ST_OK) begin
            unique case (REQ_IN.cmd)
                CMD_CHG_CODE: prot_ff <= REQ_IN.arg0;
                CMD_SET_ADDR: addr_ff <= REQ_IN.arg0;
                CMD_CFG_LINK: mode_ff <= REQ_IN.arg0;
                CMD_SET_POS: ofs_ff <= POS_IN - {REQ_IN.arg0[6:0], REQ_IN.arg1};
                default: ;
            endcase
        end
    end

    // counter wraps silently; overflow status is not reported
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            cnt_ff <= '0;
        end else if (REQ_VALID_IN && do_exec) begin
            if (REQ_IN.cmd == CMD_INC_CNT) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end else if (REQ_IN.cmd == CMD_CLR_CNT) begin
                cnt_ff <= '0;
            end
        end
    end

    // field table and storage
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            for (int i = 0; i < NFLD; i++) begin
                fld_ff[i] <= '0;
            end
            fld_ff[0] <= '{exists: 1'b1, wprot: 1'b1, fixsize: 1'b1, size: 8'h10};
        end else if (REQ_VALID_IN && do_exec && nxt_rsp.status == ST_OK) begin
            if (REQ_IN.cmd == CMD_MK_FLD) begin
                fld_ff[fi] <= '{exists: 1'b1, wprot: 1'b0, fixsize: 1'b0, size: REQ_IN.arg1};
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (REQ_VALID_IN && do_exec && nxt_rsp.status == ST_OK && REQ_IN.cmd == CMD_ST_DATA) begin
            mem[fi][wi] <= REQ_IN.arg2;
        end
    end

    // last frame error kept for read-status; a good frame other than read-status clears it
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            last_err_ff <= ST_OK;
        end else if (REQ_VALID_IN && REQ_IN.cmd != CMD_RD_STAT) begin
            last_err_ff <= nxt_rsp.status;
        end
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
            rst_req_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= REQ_VALID_IN;
            rst_req_ff <= REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_RESET;
            if (REQ_VALID_IN) begin
                rsp_ff <= nxt_rsp;
            end
        end
    end

    assign RSP_VALID_OUT = rsp_valid_ff;
    assign RSP_OUT = rsp_ff;
    assign POS_OFS_OUT = ofs_ff;
    assign LINK_ADDR_OUT = addr_ff;
    assign LINK_MODE_OUT = mode_ff;
    assign RESET_REQ_OUT = rst_req_ff;

    a_prot_guard: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && REQ_IN.chk_ok && REQ_IN.cmd == CMD_SET_ADDR && REQ_IN.prot != prot_ff
        |=> $stable(addr_ff)) else $error("address changed with wrong protection");
    a_prot_reset: assert property (@(posedge CLK_IN)
        $fell(SYS_RST_IN) |-> prot_ff == PROT_RST) else $error("protection not 55h");
    a_chk_reject: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && !REQ_IN.chk_ok |=> RSP_VALID_OUT && RSP_OUT.status == ST_CHKSUM
        && $stable(cnt_ff)) else $error("bad checksum accepted");
    a_len_check: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && REQ_IN.chk_ok && known_cmd(REQ_IN.cmd)
        && REQ_IN.nbytes != exp_len(REQ_IN.cmd) |=> RSP_OUT.status == ST_LEN)
        else $error("length error missed");
    a_wprot_store: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_ST_DATA && REQ_IN.arg0 == 8'h00
        && REQ_IN.arg1 < 8'h10 |=> RSP_OUT.status == ST_WPROT) else $error("protected store");
    a_free_mem: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_MEM_FREE
        |=> RSP_OUT.d0 == $past(free_mem)) else $error("free memory wrong");
    a_unknown_cmd: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && REQ_IN.chk_ok && !known_cmd(REQ_IN.cmd)
        |=> RSP_OUT.status == ST_UNK_CMD && $stable(prot_ff) && $stable(cnt_ff))
        else $error("unknown command mishandled");
    a_ser_num: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_SERNUM
        |=> RSP_OUT.d4 == FW_VER && RSP_OUT.d3 == SER_NUM[7:0]) else $error("serial wrong");
    // field 0 is built fixed and protected, so these checks hold whatever ran before
    a_stat_clear: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_RD_STAT && flt_code == ST_OK
        && last_err_ff == ST_OK |=> RSP_OUT.d0 == ST_OK) else $error("status not clear");
    a_speed_pos: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_RD_POS && flt_code == ST_SPEED
        |=> RSP_OUT.status == ST_SPEED && {RSP_OUT.d0, RSP_OUT.d1} == 16'h0000)
        else $error("position given at high speed");
    a_no_field: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_FLD_STAT && !fld_ff[fi].exists
        |=> RSP_OUT.status == ST_NOFLD) else $error("absent field reported");
    a_fix_size: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_MK_FLD && REQ_IN.arg0 == 8'h00
        |=> RSP_OUT.status == ST_FIXSIZE) else $error("fixed field resized");
    a_word_addr: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_RD_DATA && REQ_IN.arg0 < 8'(NFLD)
        && fld_ff[fi].exists && REQ_IN.arg1 >= fld_ff[fi].size
        |=> RSP_OUT.status == ST_WADDR) else $error("word address beyond field");
    a_reset_req: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_RESET |=> RESET_REQ_OUT)
        else $error("reset request missing");
    c_set_addr: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_SET_ADDR);
    c_make_fld: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_MK_FLD && nxt_rsp.status == ST_OK);
    c_chk_bad: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && !REQ_IN.chk_ok);
    c_speed_pos: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_RD_POS && flt_code == ST_SPEED);
    c_store_ok: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        REQ_VALID_IN && do_exec && REQ_IN.cmd == CMD_ST_DATA && nxt_rsp.status == ST_OK);
endmodule : ench_top
`default_nettype wire

// File: test/ench_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ench_ctl_model
    import ench_pkg::*;
(
    input wire logic clk_in,
    output logic req_valid_out,
    output ench_req_s req_out
);
    // a controller that has never changed the code keeps sending the delivered value
    logic [7:0] prot_code = PROT_RST;

    initial begin
        req_valid_out = 1'b0;
        req_out = '0;
    end

    // frames change just after a falling edge and hold across the taking edge
    task automatic send(input ench_req_s r, input logic keep_prot);
        ench_req_s f;
        f = r;
        if (keep_prot) begin
            f.prot = prot_code;
        end
        @(negedge clk_in);
        req_valid_out = 1'b1;
        req_out = f;
    endtask : send

    // released frame lines show the inverse so a stale frame cannot pass
    task automatic idle();
        @(negedge clk_in);
        req_valid_out = 1'b0;
        req_out = ~req_out;
    endtask : idle
endmodule : ench_ctl_model
`default_nettype wire

// File: test/encoder_command_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module encoder_command_handler_tb
    import ench_pkg::*;
;
    typedef struct packed {
        ench_rsp_s e;
        logic [5:0] m;
    } ench_exp_s;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic req_valid;
    ench_req_s req;
    logic [14:0] pos = 15'h0000;
    logic pos_run = 1'b1;
    logic [14:0] ofs_exp;
    ench_flt_s flt = '0;
    logic rsp_valid;
    ench_rsp_s rsp;
    logic [14:0] pos_ofs;
    logic [7:0] link_addr;
    logic [7:0] link_mode;
    logic reset_req;
    ench_exp_s exp_q[$];
    ench_exp_s x;
    int err_count = 0;
    int compares = 0;
    integer seed = 32'h6d0a;
    logic [7:0] r1;
    logic [7:0] r2;
    ench_req_s b;
    logic [7:0] pc[3] = '{CMD_SET_POS, CMD_SET_ADDR, CMD_CFG_LINK};
    logic [7:0] codes[6] = '{ST_OFFSET, ST_PART_TBL, ST_NVM_BUS, ST_WDOG, ST_SPEED, ST_ANA_MON};

    ench_ctl_model ctl (.clk_in(clk_in), .req_valid_out(req_valid), .req_out(req));
    ench_top dut (.CLK_IN(clk_in), .SYS_RST_IN(sys_rst_in), .REQ_VALID_IN(req_valid),
        .REQ_IN(req), .POS_IN(pos), .FLT_IN(flt), .RSP_VALID_OUT(rsp_valid), .RSP_OUT(rsp),
        .POS_OFS_OUT(pos_ofs), .LINK_ADDR_OUT(link_addr), .LINK_MODE_OUT(link_mode),
        .RESET_REQ_OUT(reset_req));

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    always @(negedge clk_in) begin
        if (pos_run) begin
            pos <= 15'($random(seed));
        end
    end

    function automatic ench_req_s fr(input logic [7:0] c, a0, a1, a2, input logic [2:0] n);
        fr = '{cmd:c, prot:8'h00, arg0:a0, arg1:a1, arg2:a2, nbytes:n, chk_ok:1'b1};
    endfunction : fr

    task automatic op(input ench_req_s r, input logic [7:0] s, input logic [39:0] d,
        input logic [5:0] m, input logic kp = 1'b1);
        exp_q.push_back('{e:ench_rsp_s'({s, d}), m:m});
        ctl.send(r, kp);
    endtask : op

    task automatic settle();
        ctl.idle();
        @(negedge clk_in);
    endtask : settle

    // the mask picks the reply bytes that mean something for that command
    always @(negedge clk_in) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("spare reply", 1'b0, 1'b1)
            end else begin
                x = exp_q.pop_front();
                if (x.m[5]) `CHK("status", x.e.status, rsp.status)
                for (int i = 0; i < 5; i++) begin
                    if (x.m[4 - i]) `CHK("data", x.e[39 - 8 * i -: 8], rsp[39 - 8 * i -: 8])
                end
            end
        end
    end

    task automatic report_and_stop();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(40 * 3000);
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        // shaft held still so the offset taken by set-position is known
        pos_run = 1'b0;
        r1 = $random(seed);
        r2 = $random(seed);
        op(fr(CMD_RD_STAT, 0, 0, 0, 0), ST_OK, 40'h0, 6'h10);
        op(fr(CMD_SET_POS, r1, r2, 0, 3), ST_OK, 40'h0, 6'h20);
        foreach (pc[i]) begin
            b = fr(pc[i], ~r1, ~r2, 0, 3);
            b.prot = PROT_RST ^ 8'h01;
            op(b, ST_CODE, 40'h0, 6'h20, 1'b0);
        end
        settle();
        ofs_exp = pos - {r1[6:0], r2};
        `CHK("offset", ofs_exp, pos_ofs)
        pos_run = 1'b1;
        `CHK("address", ADDR_RST, link_addr)
        `CHK("mode", MODE_RST, link_mode)
        op(fr(CMD_SET_ADDR, r1, 0, 0, 3), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_CFG_LINK, r2, 0, 0, 3), ST_OK, 40'h0, 6'h20);
        settle();
        `CHK("address", r1, link_addr)
        `CHK("mode", r2, link_mode)
        b = fr(CMD_RD_CNT, 0, 0, 0, 0);
        b.chk_ok = 1'b0;
        op(b, ST_CHKSUM, 40'h0, 6'h20);
        op(fr(CMD_RD_DATA, 0, 0, 0, 1), ST_LEN, 40'h0, 6'h20);
        op(fr(CMD_MK_FLD, 1, 0, 0, 2), ST_ARG, 40'h0, 6'h20);
        op(fr(CMD_MK_FLD, 1, 8'h11, 0, 2), ST_ARG, 40'h0, 6'h20);
        op(fr(CMD_ST_DATA, 0, 0, r1, 3), ST_WPROT, 40'h0, 6'h20);
        op(fr(CMD_MK_FLD, 0, 8'h08, 0, 2), ST_FIXSIZE, 40'h0, 6'h20);
        op(fr(CMD_RD_DATA, 0, 8'h10, 0, 2), ST_WADDR, 40'h0, 6'h20);
        op(fr(CMD_RD_DATA, 2, 0, 0, 2), ST_NOFLD, 40'h0, 6'h20);
        op(fr(CMD_FLD_STAT, 2, 0, 0, 1), ST_NOFLD, 40'h0, 6'h20);
        op(fr(8'h41, 0, 0, 0, 0), ST_UNK_CMD, 40'h0, 6'h20);
        op(fr(8'hFF, ~r1, 0, 0, 3), ST_UNK_CMD, 40'h0, 6'h20);
        settle();
        `CHK("address", r1, link_addr)
        op(fr(CMD_MK_FLD, 1, 8'h08, 0, 2), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_FLD_STAT, 1, 0, 0, 1), ST_OK, {16'h0800, 24'h0}, 6'h38);
        op(fr(CMD_FLD_STAT, 0, 0, 0, 1), ST_OK, {16'h1003, 24'h0}, 6'h38);
        op(fr(CMD_MEM_FREE, 0, 0, 0, 0), ST_OK, {MEM_TOTAL - 8'h18, 32'h0}, 6'h30);
        op(fr(CMD_ST_DATA, 1, 3, r2, 3), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_RD_DATA, 1, 3, 0, 2), ST_OK, {r2, 32'h0}, 6'h30);
        op(fr(CMD_RD_DATA, 1, 8'h08, 0, 2), ST_WADDR, 40'h0, 6'h20);
        op(fr(CMD_SERNUM, 0, 0, 0, 0), ST_OK, {SER_NUM, FW_VER}, 6'h3F);
        op(fr(CMD_INC_CNT, 0, 0, 0, 0), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_INC_CNT, 0, 0, 0, 0), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_RD_CNT, 0, 0, 0, 0), ST_OK, {16'h0002, 24'h0}, 6'h38);
        op(fr(CMD_CLR_CNT, 0, 0, 0, 0), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_RD_CNT, 0, 0, 0, 0), ST_OK, 40'h0, 6'h38);
        op(fr(CMD_RD_TYPE, 0, 0, 0, 0), ST_OK, {TYPE_ID, 32'h0}, 6'h30);
        op(fr(CMD_RD_ANA, 8'h48, 0, 0, 1), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_RD_ANA, 8'h47, 0, 0, 1), ST_ARG, 40'h0, 6'h20);
        op(fr(CMD_CHG_CODE, ~PROT_RST, 0, 0, 1), ST_OK, 40'h0, 6'h20);
        op(fr(CMD_SET_ADDR, r2, 0, 0, 3), ST_CODE, 40'h0, 6'h20);
        b = fr(CMD_SET_ADDR, ~r1, 0, 0, 3);
        b.prot = ~PROT_RST;
        op(b, ST_OK, 40'h0, 6'h20, 1'b0);
        op(fr(CMD_RESET, 0, 0, 0, 0), ST_OK, 40'h0, 6'h20);
        ctl.idle();
        `CHK("reset request", 1'b1, reset_req)
        @(negedge clk_in);
        `CHK("reset request", 1'b0, reset_req)
        `CHK("address", ~r1, link_addr)
        // faults are synchronised, so give them time to land before asking
        for (int i = 0; i < 6; i++) begin
            flt = 6'b100000 >> i;
            repeat (4) @(negedge clk_in);
            op(fr(CMD_RD_STAT, 0, 0, 0, 0), 8'h00, {codes[i], 32'h0}, 6'h10);
            if (i == 4) op(fr(CMD_RD_POS, 0, 0, 0, 0), ST_SPEED, 40'h0, 6'h20);
            settle();
        end
        flt = 6'b111111;
        repeat (4) @(negedge clk_in);
        op(fr(CMD_RD_STAT, 0, 0, 0, 0), 8'h00, {ST_OFFSET, 32'h0}, 6'h10);
        settle();
        flt = '0;
        pos_run = 1'b0;
        repeat (4) @(negedge clk_in);
        op(fr(CMD_RD_POS, 0, 0, 0, 0), ST_OK, {1'b0, pos - ofs_exp, 24'h0}, 6'h38);
        settle();
        repeat (2) @(negedge clk_in);
        `CHK("pending replies", 0, exp_q.size())
        report_and_stop();
    end
endmodule : encoder_command_handler_tb
`default_nettype wire
